// ---- sfod_device.sv ----
// device end: serial flash instruction decoder
`timescale 1ns/1ns
`default_nettype none
module sfod_device
    import sfod_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       addr32_mode,
    output sfod_cmd_t       cmd_class,
    output logic [1:0]      cmd_addr_kind,
    output logic [7:0]      cmd_max_mhz,
    output logic            cmd_strobe,
    output logic            cmd_unknown,
    output logic            fail_clear,
    sfod_link_if.device     link
);
    // ****************************************
    // link domain: shift the instruction
    // ****************************************
    // cs_n is async to sck, so frame reset uses it directly as a level
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic [7:0] op_q;
    logic       tog_q;

    always_ff @(posedge link.sck or posedge link.cs_n)
    begin
        if (link.cs_n)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'(INSTR_BITS))
        begin
            sh_q  <= {sh_q[6:0], link.io_lane0};
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // byte complete: capture opcode and flip the event toggle
    // rst clears the toggle so both sides of the crossing restart equal;
    // sck stands low while rst is high, so the release meets no link edge
    wire byte_last = !link.cs_n && (cnt_q == 4'(INSTR_BITS - 1));
    always_ff @(posedge link.sck or posedge rst)
    begin
        if (rst)
        begin
            op_q  <= 8'h00;
            tog_q <= 1'b0;
        end
        else if (byte_last)
        begin
            op_q  <= {sh_q[6:0], link.io_lane0};
            tog_q <= !tog_q;
        end
    end

    // ****************************************
    // system domain: cross and decode
    // ****************************************
    logic [2:0] tog_sync_q;
    logic [7:0] op_sync_q;
    logic [7:0] op_sync2_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            tog_sync_q <= 3'h0;
        else
            tog_sync_q <= {tog_sync_q[1:0], tog_q};
    end

    // opcode passes two stages and reaches op_sync2_q in the same cycle new_op rises
    always_ff @(posedge clk)
    begin
        op_sync_q  <= op_q;
        op_sync2_q <= op_sync_q;
    end

    wire new_op = tog_sync_q[2] ^ tog_sync_q[1];

    sfod_cmd_t  dec_class;
    logic [1:0] dec_addr;
    logic [7:0] dec_mhz;

    always_comb
    begin
        dec_addr = ADDR_NONE;
        dec_mhz  = 8'(FREQ_DEFAULT_MHZ);
        case (op_sync2_q)
            OP_READ:          begin dec_class = SFOD_CMD_READ; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_READ_MHZ); end
            OP_PAGE_PROGRAM:  begin dec_class = SFOD_CMD_PAGE_PROGRAM; dec_addr = ADDR_SEL; end
            OP_PP_ADDR32:     begin dec_class = SFOD_CMD_PAGE_PROGRAM_ADDR32;
                                    dec_addr = ADDR_FOUR; end
            OP_FAST_READ32:   begin dec_class = SFOD_CMD_FAST_READ_ADDR32;
                                    dec_addr = ADDR_FOUR; end
            OP_DDR_FAST_READ: begin dec_class = SFOD_CMD_DDR_FAST_READ; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_DDR_MHZ); end
            OP_SMALL_ERASE:   begin dec_class = SFOD_CMD_SMALL_SECTOR_ERASE;
                                    dec_addr = ADDR_SEL; end
            OP_SMALL_ERASE32: begin dec_class = SFOD_CMD_SMALL_SECTOR_ERASE_ADDR32;
                                    dec_addr = ADDR_FOUR; end
            OP_CLEAR_STATUS:  dec_class = SFOD_CMD_CLEAR_STATUS;
            OP_QPP_A, OP_QPP_B:
                              begin dec_class = SFOD_CMD_QUAD_PAGE_PROGRAM; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_QPP_MHZ); end
            OP_QPP_ADDR32:    begin dec_class = SFOD_CMD_QUAD_PAGE_PROGRAM_ADDR32;
                                    dec_addr = ADDR_FOUR; dec_mhz = 8'(FREQ_QPP_MHZ); end
            OP_DUAL_READ:     begin dec_class = SFOD_CMD_DUAL_OUTPUT_READ; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_MULTI_MHZ); end
            OP_DUAL_READ32:   begin dec_class = SFOD_CMD_DUAL_OUTPUT_READ_ADDR32;
                                    dec_addr = ADDR_FOUR; dec_mhz = 8'(FREQ_MULTI_MHZ); end
            OP_QUAD_READ:     begin dec_class = SFOD_CMD_QUAD_OUTPUT_READ; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_MULTI_MHZ); end
            OP_TP_WRITE_VOL:  dec_class = SFOD_CMD_TP_WRITE_VOLATILE;
            OP_TP_PROG_NV:    dec_class = SFOD_CMD_TP_PROGRAM_NV;
            OP_TP_READ:       dec_class = SFOD_CMD_TP_READ;
            OP_ARRAY_ERASE_A, OP_ARRAY_ERASE_B:
                              dec_class = SFOD_CMD_WHOLE_ARRAY_ERASE;
            OP_LARGE_ERASE:   begin dec_class = SFOD_CMD_LARGE_SECTOR_ERASE;
                                    dec_addr = ADDR_SEL; end
            OP_LARGE_ERASE32: begin dec_class = SFOD_CMD_LARGE_SECTOR_ERASE_ADDR32;
                                    dec_addr = ADDR_FOUR; end
            OP_ERASE_SUSP:    dec_class = SFOD_CMD_ERASE_SUSPEND;
            OP_ERASE_RESUME:  dec_class = SFOD_CMD_ERASE_RESUME;
            OP_PROG_SUSP:     dec_class = SFOD_CMD_PROGRAM_SUSPEND;
            OP_PROG_RESUME:   dec_class = SFOD_CMD_PROGRAM_RESUME;
            OP_IDENTITY_READ: dec_class = SFOD_CMD_IDENTITY_READ;
            OP_BANK_ACCESS:   dec_class = SFOD_CMD_BANK_ACCESS;
            OP_DDR_QUAD_IO:   begin dec_class = SFOD_CMD_DDR_QUAD_IO_READ; dec_addr = ADDR_SEL;
                                    dec_mhz = 8'(FREQ_DDR_MHZ); end
            OP_PASSWORD_READ: dec_class = SFOD_CMD_PASSWORD_READ;
            OP_PASSWORD_PROG: dec_class = SFOD_CMD_PASSWORD_PROGRAM;
            OP_PASSWORD_UNLK: dec_class = SFOD_CMD_PASSWORD_UNLOCK;
            OP_SOFT_RESET:    dec_class = SFOD_CMD_SOFT_RESET;
            OP_MODE_BITS_RST: dec_class = SFOD_CMD_MODE_BITS_RESET;
            default:          begin dec_class = SFOD_CMD_NONE; dec_mhz = 8'h00; end
        endcase
    end

    // selectable width becomes ADDR_FOUR when addr32_mode is set and stays ADDR_SEL otherwise
    wire [1:0] dec_addr_eff = (dec_addr == ADDR_SEL) ? (addr32_mode ? ADDR_FOUR : ADDR_SEL)
                                                     : dec_addr;

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmd_class     <= SFOD_CMD_NONE;
            cmd_addr_kind <= ADDR_NONE;
            cmd_max_mhz   <= 8'h00;
            cmd_strobe    <= 1'b0;
            cmd_unknown   <= 1'b0;
            fail_clear    <= 1'b0;
        end
        else
        begin
            cmd_strobe  <= new_op && (dec_class != SFOD_CMD_NONE);
            cmd_unknown <= new_op && (dec_class == SFOD_CMD_NONE);
            fail_clear  <= new_op && (dec_class == SFOD_CMD_CLEAR_STATUS ||
                                      dec_class == SFOD_CMD_SOFT_RESET);
            if (new_op && dec_class != SFOD_CMD_NONE)
            begin
                cmd_class     <= dec_class;
                cmd_addr_kind <= dec_addr_eff;
                cmd_max_mhz   <= dec_mhz;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sfod_pkg.sv ----
// package: opcodes, command classes and clock limits for the flash opcode decoder
package sfod_pkg;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_READ          = 8'h03;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_PP_ADDR32     = 8'h12;
    localparam logic [7:0] OP_FAST_READ32   = 8'h0C;
    localparam logic [7:0] OP_DDR_FAST_READ = 8'h0D;
    localparam logic [7:0] OP_SMALL_ERASE   = 8'h20;
    localparam logic [7:0] OP_SMALL_ERASE32 = 8'h21;
    localparam logic [7:0] OP_CLEAR_STATUS  = 8'h30;
    localparam logic [7:0] OP_QPP_A         = 8'h32;
    localparam logic [7:0] OP_QPP_B         = 8'h38;
    localparam logic [7:0] OP_QPP_ADDR32    = 8'h34;
    localparam logic [7:0] OP_DUAL_READ     = 8'h3B;
    localparam logic [7:0] OP_DUAL_READ32   = 8'h3C;
    localparam logic [7:0] OP_QUAD_READ     = 8'h6B;
    localparam logic [7:0] OP_TP_WRITE_VOL  = 8'h4A;
    localparam logic [7:0] OP_TP_PROG_NV    = 8'h43;
    localparam logic [7:0] OP_TP_READ       = 8'h41;
    localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
    localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_LARGE_ERASE   = 8'hD8;
    localparam logic [7:0] OP_LARGE_ERASE32 = 8'hDC;
    localparam logic [7:0] OP_ERASE_SUSP    = 8'h75;
    localparam logic [7:0] OP_ERASE_RESUME  = 8'h7A;
    localparam logic [7:0] OP_PROG_SUSP     = 8'h85;
    localparam logic [7:0] OP_PROG_RESUME   = 8'h8A;
    localparam logic [7:0] OP_IDENTITY_READ = 8'h9F;
    localparam logic [7:0] OP_BANK_ACCESS   = 8'hB9;
    localparam logic [7:0] OP_DDR_QUAD_IO   = 8'hED;
    localparam logic [7:0] OP_PASSWORD_READ = 8'hE7;
    localparam logic [7:0] OP_PASSWORD_PROG = 8'hE8;
    localparam logic [7:0] OP_PASSWORD_UNLK = 8'hE9;
    localparam logic [7:0] OP_SOFT_RESET    = 8'hF0;
    localparam logic [7:0] OP_MODE_BITS_RST = 8'hFF;

    // ****************************************
    // command classes
    // ****************************************
    typedef enum logic [4:0] {
        SFOD_CMD_NONE,
        SFOD_CMD_READ,
        SFOD_CMD_PAGE_PROGRAM,
        SFOD_CMD_PAGE_PROGRAM_ADDR32,
        SFOD_CMD_FAST_READ_ADDR32,
        SFOD_CMD_DDR_FAST_READ,
        SFOD_CMD_SMALL_SECTOR_ERASE,
        SFOD_CMD_SMALL_SECTOR_ERASE_ADDR32,
        SFOD_CMD_CLEAR_STATUS,
        SFOD_CMD_QUAD_PAGE_PROGRAM,
        SFOD_CMD_QUAD_PAGE_PROGRAM_ADDR32,
        SFOD_CMD_DUAL_OUTPUT_READ,
        SFOD_CMD_DUAL_OUTPUT_READ_ADDR32,
        SFOD_CMD_QUAD_OUTPUT_READ,
        SFOD_CMD_TP_WRITE_VOLATILE,
        SFOD_CMD_TP_PROGRAM_NV,
        SFOD_CMD_TP_READ,
        SFOD_CMD_WHOLE_ARRAY_ERASE,
        SFOD_CMD_LARGE_SECTOR_ERASE,
        SFOD_CMD_LARGE_SECTOR_ERASE_ADDR32,
        SFOD_CMD_ERASE_SUSPEND,
        SFOD_CMD_ERASE_RESUME,
        SFOD_CMD_PROGRAM_SUSPEND,
        SFOD_CMD_PROGRAM_RESUME,
        SFOD_CMD_IDENTITY_READ,
        SFOD_CMD_BANK_ACCESS,
        SFOD_CMD_DDR_QUAD_IO_READ,
        SFOD_CMD_PASSWORD_READ,
        SFOD_CMD_PASSWORD_PROGRAM,
        SFOD_CMD_PASSWORD_UNLOCK,
        SFOD_CMD_SOFT_RESET,
        SFOD_CMD_MODE_BITS_RESET
    } sfod_cmd_t;

    // address width codes
    localparam logic [1:0] ADDR_NONE   = 2'h0;
    localparam logic [1:0] ADDR_SEL    = 2'h1; // follows current 3/4-byte setting
    localparam logic [1:0] ADDR_FOUR   = 2'h2;

    // ****************************************
    // clock limits, MHz
    // ****************************************
    localparam int FREQ_READ_MHZ    = 50;
    localparam int FREQ_DEFAULT_MHZ = 133;
    localparam int FREQ_DDR_MHZ     = 80;
    localparam int FREQ_QPP_MHZ     = 80;
    localparam int FREQ_MULTI_MHZ   = 104;

    // host clock: 50 MHz system clock
    localparam int SYS_CLK_MHZ      = 50;
    localparam int SCK_DIV_HALF     = 2; // half-period in system clocks
    localparam int INSTR_BITS       = 8;
endpackage

// ---- sfod_link_if.sv ----
// interface: serial link between host controller and opcode decoder
`timescale 1ns/1ns
`default_nettype none
interface sfod_link_if;
    logic cs_n;
    logic sck;
    logic io_lane0;
    modport host   (output cs_n, output sck, output io_lane0);
    modport device (input cs_n, input sck, input io_lane0);
endinterface
`default_nettype wire

// ---- sfod_host.sv ----
// host end: frames an eight-bit instruction on the serial link
`timescale 1ns/1ns
`default_nettype none
module sfod_host
    import sfod_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_opcode,
    output logic            cmd_ready,
    output logic            cmd_done,
    sfod_link_if.host       link
);
    // ****************************************
    // sequencing
    // ****************************************
    // the divider keeps sck at 12.5 MHz, under every class limit
    typedef enum logic [1:0] {SFOD_H_IDLE, SFOD_H_SHIFT, SFOD_H_END} sfod_hstate_t;

    sfod_hstate_t state_q;
    logic [7:0]   shift_q;
    logic [3:0]   bits_q;
    logic [1:0]   div_q;
    logic         sck_q;
    logic         cs_n_q;
    logic         ready_q;
    logic         done_q;

    wire div_end = (div_q == 2'(SCK_DIV_HALF - 1));
    wire rising  = div_end && !sck_q;
    wire falling = div_end && sck_q;

    // div_q is two bits wide
    if (SCK_DIV_HALF < 1 || SCK_DIV_HALF > 4)
        $error("sfod_host: divider out of range");

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= SFOD_H_IDLE;
            shift_q <= 8'h00;
            bits_q  <= 4'h0;
            div_q   <= 2'h0;
            sck_q   <= 1'b0;
            cs_n_q  <= 1'b1;
            ready_q <= 1'b1;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                SFOD_H_IDLE:
                begin
                    if (cmd_valid && ready_q)
                    begin
                        // chip select falls, then the instruction shifts, msb first
                        cs_n_q  <= 1'b0;
                        shift_q <= cmd_opcode;
                        bits_q  <= 4'h0;
                        div_q   <= 2'h0;
                        ready_q <= 1'b0;
                        state_q <= SFOD_H_SHIFT;
                    end
                end
                SFOD_H_SHIFT:
                begin
                    div_q <= div_end ? 2'h0 : div_q + 2'h1;
                    if (div_end)
                        sck_q <= !sck_q;
                    if (rising)
                        bits_q <= bits_q + 4'h1;
                    if (falling)
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (bits_q == 4'(INSTR_BITS))
                            state_q <= SFOD_H_END;
                    end
                end
                SFOD_H_END:
                begin
                    // select rises right after the eighth falling edge
                    cs_n_q  <= 1'b1;
                    ready_q <= 1'b1;
                    done_q  <= 1'b1;
                    state_q <= SFOD_H_IDLE;
                end
                default:
                    state_q <= SFOD_H_IDLE;
            endcase
        end
    end

    assign link.cs_n     = cs_n_q;
    assign link.sck      = sck_q;
    assign link.io_lane0 = shift_q[7];
    assign cmd_ready     = ready_q;
    assign cmd_done      = done_q;
endmodule
`default_nettype wire

// ---- sfod_chk.sv ----
// checker: link framing and decoder pulse properties
`timescale 1ns/1ns
`default_nettype none
module sfod_chk
    import sfod_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     cs_n,
    input  wire logic     sck,
    input  wire logic     io_lane0,
    input  wire logic     cmd_done,
    input  wire logic     cmd_strobe,
    input  wire logic     cmd_unknown,
    input  wire logic     fail_clear,
    input  var sfod_cmd_t cmd_class
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ****************************************
    // link framing
    // ****************************************
    chk_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock high while deselected");
    chk_frame_holds_low: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select released early in a frame");
    chk_sck_half_period: assert property ($changed(sck) |=> $stable(sck))
        else $error("serial clock half period shorter than two cycles");
    chk_data_on_fall: assert property
        (!cs_n && $past(!cs_n) && $changed(io_lane0) |-> $fell(sck))
        else $error("serial data moved away from a falling clock");
    chk_done_on_rise: assert property ($rose(cs_n) |-> cmd_done)
        else $error("frame ended without a done pulse");

    // ****************************************
    // decoder answers
    // ****************************************
    // the bound covers eight bits at four cycles each plus sync latency
    chk_decode_bounded: assert property
        ($fell(cs_n) |-> ##[28:40] (cmd_strobe || cmd_unknown))
        else $error("no decode answer after a full instruction byte");
    chk_pulse_exclusive: assert property (!(cmd_strobe && cmd_unknown))
        else $error("known and unknown pulses together");
    chk_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("decode strobe longer than one cycle");
    chk_done_single: assert property (cmd_done |=> !cmd_done)
        else $error("done longer than one cycle");
    chk_class_set: assert property (cmd_strobe |=> cmd_class != SFOD_CMD_NONE)
        else $error("known strobe left no command class");

    cover property (cmd_strobe ##[0:1] cmd_class == SFOD_CMD_MODE_BITS_RESET);
    cover property (cmd_unknown);
    cover property (fail_clear);
endmodule
`default_nettype wire

// ---- serial_flash_opcode_decoder_tb_top.sv ----
// testbench: host and decoder joined over the link, full opcode sweep
`timescale 1ns/1ns
`default_nettype none
module serial_flash_opcode_decoder_tb_top
    import sfod_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b0;
    logic       cmd_valid = 1'b0;
    logic       addr32_mode = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic       cmd_ready, cmd_done, cmd_strobe, cmd_unknown, fail_clear;
    logic [1:0] cmd_addr_kind;
    logic [7:0] cmd_max_mhz;
    sfod_cmd_t  cmd_class;
    sfod_cmd_t  last_c = SFOD_CMD_NONE;
    logic [1:0] last_k = 2'h0;
    logic [7:0] last_m = 8'h00;
    int         err_count = 0;
    int         num_checks = 0;
    logic [7:0] four_only [6] = '{OP_PP_ADDR32, OP_FAST_READ32, OP_SMALL_ERASE32,
                                  OP_QPP_ADDR32, OP_DUAL_READ32, OP_LARGE_ERASE32};

    sfod_link_if link_if ();
    sfod_host u_sfod_host (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .link(link_if));
    sfod_device u_sfod_device (.clk(clk), .rst(rst), .addr32_mode(addr32_mode),
        .cmd_class(cmd_class), .cmd_addr_kind(cmd_addr_kind), .cmd_max_mhz(cmd_max_mhz),
        .cmd_strobe(cmd_strobe), .cmd_unknown(cmd_unknown), .fail_clear(fail_clear),
        .link(link_if));
    sfod_chk u_sfod_chk (.clk(clk), .rst(rst), .cs_n(link_if.cs_n), .sck(link_if.sck),
        .io_lane0(link_if.io_lane0), .cmd_done(cmd_done), .cmd_strobe(cmd_strobe),
        .cmd_unknown(cmd_unknown), .fail_clear(fail_clear), .cmd_class(cmd_class));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ****************************************
    // expectations
    // ****************************************
    function automatic void expect_of(input logic [7:0] op, input logic a32,
        output sfod_cmd_t c, output logic [1:0] k, output logic [7:0] m);
        c = SFOD_CMD_NONE;
        case (op)
            OP_READ:          c = SFOD_CMD_READ;
            OP_PAGE_PROGRAM:  c = SFOD_CMD_PAGE_PROGRAM;
            OP_PP_ADDR32:     c = SFOD_CMD_PAGE_PROGRAM_ADDR32;
            OP_FAST_READ32:   c = SFOD_CMD_FAST_READ_ADDR32;
            OP_DDR_FAST_READ: c = SFOD_CMD_DDR_FAST_READ;
            OP_SMALL_ERASE:   c = SFOD_CMD_SMALL_SECTOR_ERASE;
            OP_SMALL_ERASE32: c = SFOD_CMD_SMALL_SECTOR_ERASE_ADDR32;
            OP_CLEAR_STATUS:  c = SFOD_CMD_CLEAR_STATUS;
            OP_QPP_A:         c = SFOD_CMD_QUAD_PAGE_PROGRAM;
            OP_QPP_B:         c = SFOD_CMD_QUAD_PAGE_PROGRAM;
            OP_QPP_ADDR32:    c = SFOD_CMD_QUAD_PAGE_PROGRAM_ADDR32;
            OP_DUAL_READ:     c = SFOD_CMD_DUAL_OUTPUT_READ;
            OP_DUAL_READ32:   c = SFOD_CMD_DUAL_OUTPUT_READ_ADDR32;
            OP_QUAD_READ:     c = SFOD_CMD_QUAD_OUTPUT_READ;
            OP_TP_WRITE_VOL:  c = SFOD_CMD_TP_WRITE_VOLATILE;
            OP_TP_PROG_NV:    c = SFOD_CMD_TP_PROGRAM_NV;
            OP_TP_READ:       c = SFOD_CMD_TP_READ;
            OP_ARRAY_ERASE_A: c = SFOD_CMD_WHOLE_ARRAY_ERASE;
            OP_ARRAY_ERASE_B: c = SFOD_CMD_WHOLE_ARRAY_ERASE;
            OP_LARGE_ERASE:   c = SFOD_CMD_LARGE_SECTOR_ERASE;
            OP_LARGE_ERASE32: c = SFOD_CMD_LARGE_SECTOR_ERASE_ADDR32;
            OP_ERASE_SUSP:    c = SFOD_CMD_ERASE_SUSPEND;
            OP_ERASE_RESUME:  c = SFOD_CMD_ERASE_RESUME;
            OP_PROG_SUSP:     c = SFOD_CMD_PROGRAM_SUSPEND;
            OP_PROG_RESUME:   c = SFOD_CMD_PROGRAM_RESUME;
            OP_IDENTITY_READ: c = SFOD_CMD_IDENTITY_READ;
            OP_BANK_ACCESS:   c = SFOD_CMD_BANK_ACCESS;
            OP_DDR_QUAD_IO:   c = SFOD_CMD_DDR_QUAD_IO_READ;
            OP_PASSWORD_READ: c = SFOD_CMD_PASSWORD_READ;
            OP_PASSWORD_PROG: c = SFOD_CMD_PASSWORD_PROGRAM;
            OP_PASSWORD_UNLK: c = SFOD_CMD_PASSWORD_UNLOCK;
            OP_SOFT_RESET:    c = SFOD_CMD_SOFT_RESET;
            OP_MODE_BITS_RST: c = SFOD_CMD_MODE_BITS_RESET;
            default:          c = SFOD_CMD_NONE;
        endcase
        case (op)
            OP_READ, OP_PAGE_PROGRAM, OP_DDR_FAST_READ, OP_SMALL_ERASE, OP_QPP_A, OP_QPP_B,
            OP_DUAL_READ, OP_QUAD_READ, OP_LARGE_ERASE, OP_DDR_QUAD_IO:
                k = a32 ? ADDR_FOUR : ADDR_SEL;
            OP_PP_ADDR32, OP_FAST_READ32, OP_SMALL_ERASE32, OP_QPP_ADDR32, OP_DUAL_READ32,
            OP_LARGE_ERASE32:
                k = ADDR_FOUR;
            default: k = ADDR_NONE;
        endcase
        case (op)
            OP_READ:                                    m = 8'(FREQ_READ_MHZ);
            OP_DDR_FAST_READ, OP_DDR_QUAD_IO:           m = 8'(FREQ_DDR_MHZ);
            OP_QPP_A, OP_QPP_B, OP_QPP_ADDR32:          m = 8'(FREQ_QPP_MHZ);
            OP_DUAL_READ, OP_DUAL_READ32, OP_QUAD_READ: m = 8'(FREQ_MULTI_MHZ);
            default:                                    m = 8'(FREQ_DEFAULT_MHZ);
        endcase
    endfunction

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one frame through the host; pulses are counted until eight cycles past done
    task automatic run_cmd(input logic [7:0] op, input logic a32);
        sfod_cmd_t  c;
        logic [1:0] k;
        logic [7:0] m;
        int         ns = 0;
        int         nu = 0;
        int         nf = 0;
        int         nd = 0;
        int         nr = 0;
        int         w = 0;
        expect_of(op, a32, c, k, m);
        @(posedge clk);
        addr32_mode <= a32;
        cmd_opcode <= op;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (nd < 9 && w < 200)
        begin
            @(negedge clk);
            w++;
            ns += (cmd_strobe !== 1'b0);
            nu += (cmd_unknown !== 1'b0);
            nf += (fail_clear !== 1'b0);
            nr += (cmd_ready === 1'b0);
            if (cmd_done === 1'b1 || nd > 0)
                nd++;
        end
        if (c != SFOD_CMD_NONE)
        begin
            last_c = c;
            last_k = k;
            last_m = m;
        end
        check("done seen", 32'(nd == 9), 32'h1);
        check("ready low cycles", nr, 32'(2 * SCK_DIV_HALF * INSTR_BITS + 1));
        check("ready after frame", 32'(cmd_ready), 32'h1);
        check("strobe count", ns, 32'(c != SFOD_CMD_NONE));
        check("unknown count", nu, 32'(c == SFOD_CMD_NONE));
        check("fail clear count", nf, 32'(op == OP_CLEAR_STATUS || op == OP_SOFT_RESET));
        check("class", 32'(cmd_class), 32'(last_c));
        check("address kind", 32'(cmd_addr_kind), 32'(last_k));
        check("max mhz", 32'(cmd_max_mhz), 32'(last_m));
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(48));
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 256; i++)
            run_cmd(8'(i), 1'($urandom));
        repeat (16) run_cmd(8'($urandom), 1'($urandom));
        // four-byte-only codes must ignore a three-byte setting
        foreach (four_only[j])
            run_cmd(four_only[j], 1'b0);
        run_cmd(OP_DDR_QUAD_IO, 1'b0);
        run_cmd(OP_DDR_QUAD_IO, 1'b1);
        // reset in mid-frame: nothing may be decoded from the cut byte
        @(posedge clk);
        cmd_opcode <= OP_CLEAR_STATUS;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        last_c = SFOD_CMD_NONE;
        last_k = 2'h0;
        last_m = 8'h00;
        repeat (50) @(negedge clk);
        check("select after reset", 32'(link_if.cs_n), 32'h1);
        check("class after reset", 32'(cmd_class), 32'(SFOD_CMD_NONE));
        run_cmd(OP_MODE_BITS_RST, 1'b0);
        report_and_stop();
    end

    // about 300 frames of under 50 cycles each
    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
